// ===== rtl/adc_seq_pkg.sv
package adc_seq_pkg;

    // Register offsets are halfword indices; the byte address is four times the index.
    localparam logic [9:0] IDX_CONTROL_ONE = 10'h00C;
    localparam logic [9:0] IDX_STATUS = 10'h00E;
    localparam logic [9:0] IDX_RIGHT_UNSIGNED = 10'h010;
    localparam logic [9:0] IDX_LEFT_SIGNED = 10'h020;
    localparam logic [9:0] IDX_LEFT_UNSIGNED = 10'h030;
    localparam logic [9:0] IDX_RESOLUTION = 10'h040;
    localparam logic [9:0] IDX_IRQ_STATUS = 10'h042;
    localparam logic [9:0] IDX_IRQ_MASK = 10'h044;

    // Width of the byte address that the slave decodes.
    localparam int ADDR_W = 12;
    // Each result view spans sixteen halfword indices: eight slots, two apart.
    localparam int VIEW_SPAN = 16;
    localparam int RESULT_COUNT = 8;

    // Status register field positions.
    localparam int STAT_SEQ_FLAG_BIT = 15;
    localparam int STAT_PTR_LSB = 8;

    // Control register one layout, bits 6..0, reset all zero.
    typedef struct packed {
        logic continuous_scan;
        logic multichannel_select;
        logic eight_conversion_select;
        logic [3:0] channel_select;
    } control_one_t;
    localparam control_one_t CONTROL_ONE_RESET = '0;
    localparam int CONTROL_ONE_W = 7;

    // Channel codes with a fixed meaning.
    localparam logic [3:0] CODE_GROUNDED_INPUT_SEVEN = 4'h7;
    localparam logic [3:0] CODE_RESERVED_BLOCK = 4'h8;
    localparam logic [1:0] REFERENCE_BLOCK = 2'b11;

    // Sequence lengths minus one.
    localparam logic [2:0] LAST_OF_FOUR = 3'h3;
    localparam logic [2:0] LAST_OF_EIGHT = 3'h7;

    // Interrupt event bit positions.
    localparam int IRQ_SEQ_BIT = 0;
    localparam int IRQ_CONV_BIT = 1;
    localparam int IRQ_W = 2;

    // Request sent to the analog core.
    typedef struct packed {
        logic start;
        logic abort;
        logic [3:0] code;
    } conv_request_t;

    // Answer from the analog core.
    typedef struct packed {
        logic done;
        logic [9:0] data;
    } conv_answer_t;

    // Sequencer states.
    typedef enum logic [1:0] {
        SEQ_IDLE,
        SEQ_ISSUE,
        SEQ_WAIT
    } seq_state_t;

endpackage

// ===== rtl/adc_sequence_status_results.sv
`timescale 1ns/1ps

module adc_sequence_status_results
    import adc_seq_pkg::*;
(
    // Clock and reset.
    input wire logic sys_clk,
    input wire logic reset,
    // APB slave.
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Analog core request.
    output conv_request_t conv_req,
    // Analog core answer.
    input wire conv_answer_t conv_ans,
    // Interrupt.
    output logic irq
);

    // Software-visible control state.
    // These only change on bus writes; hardware never modifies them.
    control_one_t control_one;
    control_one_t next_control_one;
    logic res10;
    logic next_res10;
    logic [IRQ_W-1:0] irq_mask;
    logic [IRQ_W-1:0] next_irq_mask;

    // Sequencer state.
    // The pointer and flags are what software sees in the status register.
    seq_state_t state;
    seq_state_t next_state;
    logic [2:0] pointer;
    logic [2:0] next_pointer;
    logic seq_flag;
    logic next_seq_flag;
    logic [RESULT_COUNT-1:0] complete;
    logic [RESULT_COUNT-1:0] next_complete;
    conv_request_t next_conv_req;

    // Result storage: raw ten-bit value plus the resolution it was taken at.
    // Keeping the resolution per slot lets a later mode change leave old results readable.
    logic [9:0] result_value [RESULT_COUNT];
    logic result_res10 [RESULT_COUNT];
    logic [9:0] next_result_value [RESULT_COUNT];
    logic next_result_res10 [RESULT_COUNT];

    // Interrupt state.
    // Two sticky event bits share one mask and one output pin.
    logic [IRQ_W-1:0] irq_status;
    logic [IRQ_W-1:0] next_irq_status;
    logic next_irq;

    // Bus answer state.
    // Next values of the registered bus outputs.
    logic [31:0] next_prdata;
    logic next_pready;
    logic next_pslverr;

    // Decoded bus activity.
    // Single-cycle strobes derived from the committing edge.
    logic access_done;
    logic write_control_one;
    logic [RESULT_COUNT-1:0] result_read;
    logic status_read;
    logic irq_status_read;
    logic [2:0] last_slot;
    logic [3:0] slot_code;
    logic seq_end;
    logic conv_event;

    // Maps a halfword index to its byte address.
    // Appending two zero bits multiplies by four without a wider product.
    function automatic logic [ADDR_W-1:0] byte_addr(input logic [9:0] idx);
        byte_addr = {idx, 2'b00};
    endfunction

    // True when the address hits one of the eight slots of a result view.
    // Misaligned addresses inside a view fall through to the error answer.
    function automatic logic in_view(input logic [ADDR_W-1:0] a, input logic [9:0] base);
        logic [ADDR_W-1:0] off;
        off = a - byte_addr(base);
        in_view = (a >= byte_addr(base)) && (off < ADDR_W'(VIEW_SPAN * 4))
            && (off[2:0] == 3'b000);
    endfunction

    // Formats one stored result for each of the three views.
    // View 0 is right unsigned, 1 left signed and 2 left unsigned.
    function automatic logic [15:0] format_view(input logic [9:0] v, input logic r10,
                                                input logic [1:0] view);
        logic [15:0] left;
        left = r10 ? {v, 6'b000000} : {v[7:0], 8'h00};
        unique case (view)
            2'd0: format_view = r10 ? {6'b000000, v} : {8'h00, v[7:0]};
            2'd1: format_view = {~left[15], left[14:0]};
            default: format_view = left;
        endcase
    endfunction

    // A completed access is the access phase edge; writes and read side effects happen here.
    // Because pready is high for exactly one cycle, each transfer commits once, even when
    // the master holds psel high into a back-to-back setup.
    assign access_done = psel && penable && pready;
    assign write_control_one = access_done && pwrite
        && (paddr == byte_addr(IDX_CONTROL_ONE));
    // Reading the status register has no side effect; only result reads and control-one writes clear complete bits.
    assign status_read = access_done && !pwrite && (paddr == byte_addr(IDX_STATUS));
    // Reading the interrupt status clears every event bit that is not set again at once.
    assign irq_status_read = access_done && !pwrite && (paddr == byte_addr(IDX_IRQ_STATUS));

    // Any of the three views of a result counts as reading that result.
    // Each slot sits eight bytes above the previous one in every view.
    genvar gi;
    generate
        for (gi = 0; gi < RESULT_COUNT; gi++) begin : g_read
            localparam logic [ADDR_W-1:0] OFS = ADDR_W'(gi * 8);
            assign result_read[gi] = access_done && !pwrite
                && ((paddr == byte_addr(IDX_RIGHT_UNSIGNED) + OFS)
                || (paddr == byte_addr(IDX_LEFT_SIGNED) + OFS)
                || (paddr == byte_addr(IDX_LEFT_UNSIGNED) + OFS));
        end
    endgenerate

    // Sequence length follows the eight-conversion bit.
    // The bit only changes on a control-one write, which also restarts the pointer.
    assign last_slot = control_one.eight_conversion_select ? LAST_OF_EIGHT
        : LAST_OF_FOUR;

    // Channel code of the slot the pointer names, in the single-channel code space.
    // Mapping every mode onto one code space keeps the analog request a single field.
    always_comb begin
        if (!control_one.multichannel_select) begin
            // Single channel: every slot converts the same source.
            slot_code = control_one.channel_select;
        end else if (!control_one.eight_conversion_select) begin
            // Block 10 lands on codes 8..11, which are the reserved ones.
            slot_code = {control_one.channel_select[3:2], pointer[1:0]};
        end else if (!control_one.channel_select[3]) begin
            // Top bit clear: inputs zero to seven in slot order.
            slot_code = {1'b0, pointer};
        end else begin
            // Top bit set: four reserved slots, then the four reference codes.
            slot_code = pointer[2] ? {REFERENCE_BLOCK, pointer[1:0]}
                : CODE_RESERVED_BLOCK;
        end
    end

    // A sequence ends when the last slot's conversion comes back.
    // Done pulses outside the wait state are ignored, so a stray answer cannot move the pointer.
    assign seq_end = (state == SEQ_WAIT) && conv_ans.done && (pointer == last_slot);
    assign conv_event = (state == SEQ_WAIT) && conv_ans.done;

    // Control register next values.
    always_comb begin
        next_control_one = control_one;
        next_res10 = res10;
        next_irq_mask = irq_mask;
        if (write_control_one) begin
            // Only the seven defined bits are kept; upper write data is dropped.
            next_control_one = pwdata[CONTROL_ONE_W-1:0];
        end
        if (access_done && pwrite && (paddr == byte_addr(IDX_RESOLUTION))) begin
            // Resolution applies to conversions that finish from now on.
            next_res10 = pwdata[0];
        end
        if (access_done && pwrite && (paddr == byte_addr(IDX_IRQ_MASK))) begin
            // Masking hides a pending event from the pin without clearing it.
            next_irq_mask = pwdata[IRQ_W-1:0];
        end
    end

    // Control registers.
    // Reset leaves the converter idle, in eight-bit mode, with every interrupt masked.
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            control_one <= CONTROL_ONE_RESET;
            res10 <= 1'b0;
            irq_mask <= '0;
        end else begin
            control_one <= next_control_one;
            res10 <= next_res10;
            irq_mask <= next_irq_mask;
        end
    end

    // Sequencer and result capture next values.
    always_comb begin
        next_state = state;
        next_pointer = pointer;
        next_seq_flag = seq_flag;
        next_complete = complete;
        next_result_value = result_value;
        next_result_res10 = result_res10;
        next_conv_req = '{start: 1'b0, abort: 1'b0, code: conv_req.code};
        // A read clears a complete bit first so a same-cycle finish can set it again.
        next_complete = complete & ~result_read;
        if (write_control_one) begin
            // A new sequence always starts; one in flight is told to stop.
            // The write outranks a finishing conversion in the same cycle, so a late result
            // never lands in the fresh sequence.
            next_conv_req.abort = (state != SEQ_IDLE);
            next_pointer = '0;
            next_seq_flag = 1'b0;
            next_complete = '0;
            next_state = SEQ_ISSUE;
        end else begin
            unique case (state)
                SEQ_IDLE: begin
                    // Idle until software writes control one again.
                    next_state = SEQ_IDLE;
                end
                SEQ_ISSUE: begin
                    // Issue lasts one cycle, so start is always a single pulse.
                    next_conv_req.start = 1'b1;
                    next_conv_req.code = slot_code;
                    next_state = SEQ_WAIT;
                end
                SEQ_WAIT: begin
                    // The analog core may take any number of cycles; there is no timeout here.
                    if (conv_ans.done) begin
                        // The grounded input always yields the ground-level code.
                        next_result_value[pointer] =
                            (conv_req.code == CODE_GROUNDED_INPUT_SEVEN) ? '0
                            : conv_ans.data;
                        next_result_res10[pointer] = res10;
                        next_complete[pointer] = 1'b1;
                        if (pointer == last_slot) begin
                            // Last slot: flag the sequence and wrap, looping only in scan mode.
                            next_seq_flag = 1'b1;
                            next_pointer = '0;
                            next_state = control_one.continuous_scan ? SEQ_ISSUE
                                : SEQ_IDLE;
                        end else begin
                            // Otherwise move on to the next slot of the same sequence.
                            next_pointer = pointer + 3'd1;
                            next_state = SEQ_ISSUE;
                        end
                    end
                end
            endcase
        end
    end

    // Sequencer registers; results have no reset value and hold their last capture.
    // Leaving results unreset saves reset routing on the storage bits; a slot that was
    // never written reads unknown data until its first conversion.
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            state <= SEQ_IDLE;
            pointer <= '0;
            seq_flag <= 1'b0;
            complete <= '0;
            conv_req <= '0;
        end else begin
            state <= next_state;
            pointer <= next_pointer;
            seq_flag <= next_seq_flag;
            complete <= next_complete;
            conv_req <= next_conv_req;
        end
    end

    // Result storage registers.
    // These flops have no reset, so their process has no reset branch.
    always_ff @(posedge sys_clk) begin
        result_value <= next_result_value;
        result_res10 <= next_result_res10;
    end

    // Interrupt next values; an event in the clearing read's cycle survives.
    always_comb begin
        next_irq_status = irq_status_read ? '0 : irq_status;
        // An aborted sequence raises no event, matching the cleared status bits.
        if (seq_end && !write_control_one) begin
            next_irq_status[IRQ_SEQ_BIT] = 1'b1;
        end
        if (conv_event && !write_control_one) begin
            next_irq_status[IRQ_CONV_BIT] = 1'b1;
        end
        // Using the next mask lets a mask write act on the pin at the same edge.
        next_irq = |(next_irq_status & next_irq_mask);
    end

    // Interrupt registers.
    // The pin is registered so it never glitches while status and mask settle.
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            irq_status <= '0;
            irq <= 1'b0;
        end else begin
            irq_status <= next_irq_status;
            irq <= next_irq;
        end
    end

    // Bus answer: data is latched in the setup cycle, so every access has no wait state.
    always_comb begin
        next_prdata = '0;
        next_pslverr = 1'b0;
        // Ready follows every setup cycle, so no access ever waits.
        next_pready = psel && !penable;
        if (psel && !penable) begin
            if (paddr == byte_addr(IDX_CONTROL_ONE)) begin
                next_prdata[CONTROL_ONE_W-1:0] = control_one;
            end else if (paddr == byte_addr(IDX_STATUS)) begin
                // Unused bits 14 to 11 and the upper half read as zero.
                next_prdata[STAT_SEQ_FLAG_BIT] = seq_flag;
                next_prdata[STAT_PTR_LSB +: 3] = pointer;
                next_prdata[RESULT_COUNT-1:0] = complete;
            end else if (in_view(paddr, IDX_RIGHT_UNSIGNED)) begin
                next_prdata[15:0] = format_view(result_value[paddr[5:3]],
                    result_res10[paddr[5:3]], 2'd0);
            end else if (in_view(paddr, IDX_LEFT_SIGNED)) begin
                next_prdata[15:0] = format_view(result_value[paddr[5:3]],
                    result_res10[paddr[5:3]], 2'd1);
            end else if (in_view(paddr, IDX_LEFT_UNSIGNED)) begin
                next_prdata[15:0] = format_view(result_value[paddr[5:3]],
                    result_res10[paddr[5:3]], 2'd2);
            end else if (paddr == byte_addr(IDX_RESOLUTION)) begin
                next_prdata[0] = res10;
            end else if (paddr == byte_addr(IDX_IRQ_STATUS)) begin
                next_prdata[IRQ_W-1:0] = irq_status;
            end else if (paddr == byte_addr(IDX_IRQ_MASK)) begin
                next_prdata[IRQ_W-1:0] = irq_mask;
            end else begin
                // Unmapped addresses answer with an error and zero data.
                next_pslverr = 1'b1;
            end
        end
        // Writes answer with zero data; only reads return register contents.
        if (pwrite) begin
            next_prdata = '0;
        end
    end

    // Bus answer registers.
    // Registering the answer keeps every bus output straight from a flop.
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            prdata <= '0;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            prdata <= next_prdata;
            pready <= next_pready;
            pslverr <= next_pslverr;
        end
    end

endmodule

// ===== sim/adc_sequence_status_results_monitor.sv
`timescale 1ns/1ps

// Watches the bus answers and the analog requests at the top ports.
module adc_sequence_status_results_monitor
    import adc_seq_pkg::*;
(
    // Clock and reset.
    input wire logic sys_clk,
    input wire logic reset,
    // Bus side.
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Analog side.
    input wire conv_request_t conv_req
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);

    // Commit edge of a control-one write.
    wire logic ctl_wr = psel && penable && pready && pwrite && paddr == {IDX_CONTROL_ONE, 2'b00};
    // A read answer is on the bus.
    wire logic rd_ans = pready && !pwrite;

    a_ready_after_setup: assert property (psel && !penable |=> pready)
        else $error("ready missing after setup");
    a_ready_one_cycle: assert property (pready |=> !pready)
        else $error("ready held too long");
    a_start_after_write: assert property (ctl_wr |-> ##2 conv_req.start)
        else $error("no start after control write");
    a_start_pulse: assert property (conv_req.start |=> !conv_req.start)
        else $error("start longer than one cycle");
    a_abort_pulse: assert property (conv_req.abort |=> !conv_req.abort)
        else $error("abort longer than one cycle");
    a_code_holds: assert property ($changed(conv_req.code) |-> conv_req.start)
        else $error("code moved without start");
    a_idle_data_zero: assert property (!rd_ans |-> prdata == 32'h0)
        else $error("read data outside an answer");
    a_status_unused: assert property (rd_ans && paddr == {IDX_STATUS, 2'b00}
        |-> prdata[31:16] == 16'h0 && prdata[14:11] == 4'h0 && !pslverr)
        else $error("status unused bits set");
    a_right_upper_zero: assert property (rd_ans && paddr[11:6] == 6'h01
        |-> prdata[31:10] == 22'h0)
        else $error("right view upper bits set");
    a_left_low_zero: assert property (rd_ans && paddr[11:7] == 5'h01
        |-> prdata[5:0] == 6'h0 && prdata[31:16] == 16'h0)
        else $error("left view low bits set");
endmodule

bind adc_sequence_status_results adc_sequence_status_results_monitor u_mon (.sys_clk,
    .reset, .psel, .penable, .pwrite, .paddr, .prdata, .pready, .pslverr, .conv_req);

// ===== sim/adc_sequence_status_results_test.sv
`timescale 1ns/1ps

// Self-checking bench: drives the bus and answers the analog core by hand.
module adc_sequence_status_results_test;
    import adc_seq_pkg::*;
    // Byte addresses are four times the register index.
    localparam logic [11:0] A_CTL = {IDX_CONTROL_ONE, 2'b00};
    localparam logic [11:0] A_STAT = {IDX_STATUS, 2'b00};
    localparam logic [11:0] A_RJ = {IDX_RIGHT_UNSIGNED, 2'b00};
    localparam logic [11:0] A_LS = {IDX_LEFT_SIGNED, 2'b00};
    localparam logic [11:0] A_LU = {IDX_LEFT_UNSIGNED, 2'b00};
    localparam logic [11:0] A_RES = {IDX_RESOLUTION, 2'b00};
    localparam logic [11:0] A_IRQ = {IDX_IRQ_STATUS, 2'b00};
    localparam logic [11:0] A_MSK = {IDX_IRQ_MASK, 2'b00};
    logic sys_clk = 1'b0, reset = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [ADDR_W-1:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rd;
    logic pready, pslverr, irq, err;
    conv_request_t conv_req;
    conv_answer_t conv_ans = '0;
    int errors = 0, checks_done = 0;

    adc_sequence_status_results u_adc_sequence_status_results (.sys_clk(sys_clk),
        .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .conv_req(conv_req), .conv_ans(conv_ans), .irq(irq));

    // Free-running system clock.
    initial begin
        forever #4 sys_clk = ~sys_clk;
    end

    // Compares and counts; an unknown never matches.
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            errors++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    // One bus transfer; it waits on ready as long as it takes, the watchdog ends a hang.
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        do begin
            @(posedge sys_clk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Read and compare one register.
    task automatic rdchk(input string what, input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        check(what, exp, rd);
    endtask

    // Waits for a start, checks its code, then answers with one done pulse.
    task automatic conv(input logic [3:0] code, input logic chk, input logic [9:0] data);
        int n;
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (conv_req.start !== 1'b1 && n < 200);
        check("start", 32'h1, 32'(conv_req.start));
        if (chk) begin
            check("code", 32'(code), 32'(conv_req.code));
        end
        conv_ans <= {1'b1, data};
        @(posedge sys_clk);
        conv_ans <= '0;
    endtask

    // Reset values and a refused address.
    task automatic t_reset;
        rdchk("status", A_STAT, 32'h0);
        rdchk("mask", A_MSK, 32'h0);
        apb(1'b0, 12'hFFC, 32'h0);
        check("slverr", 32'h1, 32'(err));
        check("unmapped", 32'h0, rd);
    endtask

    // Single channel, four slots, 10-bit views and the interrupt.
    task automatic t_single;
        apb(1'b1, A_RES, 32'h1);
        apb(1'b1, A_MSK, 32'h1);
        apb(1'b1, A_CTL, 32'h05);
        for (int i = 0; i < 4; i++) conv(4'h5, 1'b1, 10'h2A0 + 10'(i));
        rdchk("status", A_STAT, 32'h800F);
        check("irq", 32'h1, 32'(irq));
        rdchk("right", A_RJ + 12'h10, 32'h2A2);
        rdchk("signed", A_LS + 12'h10, 32'h2880);
        rdchk("left", A_LU + 12'h10, 32'hA880);
        rdchk("status", A_STAT, 32'h800B);
        rdchk("irq status", A_IRQ, 32'h3);
        rdchk("irq status", A_IRQ, 32'h0);
        // The pin drops at the clearing edge, so look one edge later.
        @(posedge sys_clk);
        check("irq", 32'h0, 32'(irq));
    endtask

    // Block of four, 8-bit mode; the grounded input stores zero.
    task automatic t_multi4;
        apb(1'b1, A_RES, 32'h0);
        apb(1'b1, A_CTL, 32'h27);
        for (int i = 0; i < 4; i++) conv(4'(i + 4), 1'b1, 10'h3C5);
        rdchk("right", A_RJ, 32'hC5);
        rdchk("signed", A_LS, 32'h4500);
        rdchk("grounded", A_RJ + 12'h18, 32'h0);
        rdchk("status", A_STAT, 32'h8006);
    endtask

    // Block of eight with the top select bit set: references in slots four to seven.
    task automatic t_multi8;
        apb(1'b1, A_CTL, 32'h38);
        for (int i = 0; i < 8; i++) conv(4'(i + 8), i > 3, 10'h001);
        rdchk("status", A_STAT, 32'h80FF);
    endtask

    // Continuous scan wraps, then a control write aborts it.
    task automatic t_scan;
        int n;
        n = 0;
        apb(1'b1, A_CTL, 32'h4C);
        for (int i = 0; i < 5; i++) conv(4'hC, 1'b1, 10'h010);
        rdchk("status", A_STAT, 32'h810F);
        apb(1'b1, A_CTL, 32'h0D);
        // The restart's start pulse comes while the status read runs, so catch it first.
        @(posedge sys_clk);
        check("abort", 32'h1, 32'(conv_req.abort));
        do begin
            @(posedge sys_clk);
        end while (conv_req.start !== 1'b1);
        check("restart code", 32'hD, 32'(conv_req.code));
        rdchk("status", A_STAT, 32'h0);
        conv_ans <= {1'b1, 10'h020};
        @(posedge sys_clk);
        conv_ans <= '0;
        for (int i = 0; i < 3; i++) conv(4'hD, 1'b1, 10'h020);
        rdchk("status", A_STAT, 32'h800F);
        repeat (30) begin
            @(posedge sys_clk);
            if (conv_req.start !== 1'b0) n++;
        end
        check("idle start", 32'h0, 32'(n));
    endtask

    // Single place where the run ends.
    task automatic report_and_stop;
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // Main sequence.
    initial begin
        repeat (16) @(posedge sys_clk);
        reset <= 1'b0;
        t_reset();
        t_single();
        t_multi4();
        t_multi8();
        t_scan();
        report_and_stop();
    end

    // Watchdog, well beyond the few hundred cycles the tests need.
    initial begin
        repeat (20000) @(posedge sys_clk);
        errors++;
        report_and_stop();
    end
endmodule
